// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "lane_cfg.svh"

module testbench;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0, rst_b = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, ok;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata;
    wire  [31:0] fld [7];
    int          miscompares = 0, num_checks = 0, cycles = 0;
    // writable bits per register, field words need masking since unused bits float
    logic [31:0] msk [7] = '{`LCR_MASK_OPTIONS, `LCR_MASK_OVERLAY, `LCR_MASK_CLK_SEL, `LCR_MASK_CLK_ENA,
                             `LCR_MASK_WIDTH, `LCR_MASK_WIDTH, `LCR_MASK_CDR};
    logic [31:0] cfg [7] = '{32'h1, 32'h4, 32'h35, 32'hF, 32'h7, 32'h7, 32'h2};

    lane_8b10b_config_regs dut_u (
        .core_clk_i(clk), .rst_b_i(rst_b),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .octet_swap_flavour_o(fld[0][0]), .fifo_gear_width_o(fld[0][2:1]),
        .fabric_path_select_o(fld[1][3:0]), .serializer_lane_mode_o(fld[1][7:4]),
        .fabric_rx_clock_source_o(fld[2][1:0]), .fabric_tx_clock_source_o(fld[2][3:2]),
        .coder_rx_clock_source_o(fld[2][5:4]), .coder_tx_clock_source_o(fld[2][7:6]),
        .rx_fifo_write_clock_source_o(fld[2][9:8]), .tx_fifo_read_clock_source_o(fld[2][11:10]),
        .rx_fifo_clock_side_o(fld[2][12]), .coder_rx_clock_enable_o(fld[3][0]),
        .rx_fifo_write_clock_enable_o(fld[3][1]), .coder_tx_clock_enable_o(fld[3][2]),
        .tx_fifo_read_clock_enable_o(fld[3][3]), .deser_width_o(fld[4][2:0]), .ser_width_o(fld[5][2:0]),
        .slip_source_select_o(fld[6][0]), .slip_enable_o(fld[6][1]), .config_8b10b_ok_o(ok)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // handshakes are judged at the falling edge, where flop outputs are settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            resp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk({30'h0, resp}, {30'h0, e});
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
        logic ta, tr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(rd, x);
        chk({30'h0, resp}, {30'h0, e});
    endtask : rdc

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 7; i++) rdc(8'(i * 4), `LCR_RST_WORD, lane_cfg_pkg::RESP_OKAY);
        rdc(8'h1C, 32'h0000_0024, lane_cfg_pkg::RESP_OKAY);
        for (int i = 0; i < 7; i++) chk(fld[i] & msk[i], 32'h0);
        chk({31'h0, ok}, 32'h0);
        $display("reset values done");
    endtask : t_reset

    // all-ones then zero per register proves each register's fields reach that register's pins
    task automatic t_fields;
        for (int i = 0; i < 7; i++)
        begin
            wr(8'(i * 4), 32'hFFFF_FFFF, 4'hF, lane_cfg_pkg::RESP_OKAY);
            rdc(8'(i * 4), msk[i], lane_cfg_pkg::RESP_OKAY);
            chk(fld[i] & msk[i], msk[i]);
            wr(8'(i * 4), 32'h0, 4'hF, lane_cfg_pkg::RESP_OKAY);
            @(negedge clk);
            chk(fld[i] & msk[i], 32'h0);
        end
        wr(8'h08, 32'hFFFF_FFFF, 4'hE, lane_cfg_pkg::RESP_OKAY);
        rdc(8'h08, 32'h0000_1F00, lane_cfg_pkg::RESP_OKAY);
        $display("field mapping done");
    endtask : t_fields

    task automatic t_config;
        for (int i = 0; i < 7; i++) wr(8'(i * 4), cfg[i], 4'hF, lane_cfg_pkg::RESP_OKAY);
        repeat (2) @(negedge clk);
        chk({31'h0, fld[0][0]}, {31'h0, lane_cfg_pkg::SWAP_FC});
        chk({31'h0, ok}, 32'h1);
        rdc(8'h1C, 32'h0000_01FF, lane_cfg_pkg::RESP_OKAY);
        wr(8'h18, 32'h3, 4'hF, lane_cfg_pkg::RESP_OKAY);
        repeat (2) @(negedge clk);
        chk({31'h0, ok}, 32'h0);
        rdc(8'h1C, 32'h0000_00DF, lane_cfg_pkg::RESP_OKAY);
        $display("8b10b set-up done");
    endtask : t_config

    // status and holes refuse writes and leave the registers untouched
    task automatic t_refuse;
        wr(8'h1C, 32'hFFFF_FFFF, 4'hF, lane_cfg_pkg::RESP_SLVERR);
        wr(8'h20, 32'hFFFF_FFFF, 4'hF, lane_cfg_pkg::RESP_SLVERR);
        rdc(8'h20, 32'h0, lane_cfg_pkg::RESP_SLVERR);
        rdc(8'h1C, 32'h0000_00DF, lane_cfg_pkg::RESP_OKAY);
        rdc(8'h18, 32'h3, lane_cfg_pkg::RESP_OKAY);
        $display("refused accesses done");
    endtask : t_refuse

    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_fields();
        t_config();
        t_refuse();
        report_and_stop();
    end
endmodule : testbench

// ===== rtl/axil_reg_port.sv
`timescale 1ns/1ps
`include "lane_cfg.svh"

module axil_reg_port (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // write address and data
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    // write response
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    // read address and data
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    // register file side
    reg_access_if.port       acc
);

    logic       awready_q;
    logic       wready_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic [5:0] wr_idx_q;
    logic [31:0] wr_data_q;
    logic [3:0] wr_strb_q;
    logic       arready_q;
    logic       rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [5:0] rd_idx_q;
    logic       wr_fire;
    logic       rd_fire;

    // a ready low means the item is held and waiting for its partner
    assign wr_fire = !awready_q && !wready_q && !bvalid_q;
    assign rd_fire = !arready_q && !rvalid_q;

    // write channels, either order, response after both
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            wr_idx_q  <= 6'h00;
            wr_data_q <= 32'h0000_0000;
            wr_strb_q <= 4'h0;
        end
        else
        begin
            if (awvalid_i && awready_q)
            begin
                awready_q <= 1'b0;
                wr_idx_q  <= awaddr_i[7:2];
            end
            if (wvalid_i && wready_q)
            begin
                wready_q  <= 1'b0;
                wr_data_q <= wdata_i;
                wr_strb_q <= wstrb_i;
            end
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= acc.wr_ok ? lane_cfg_pkg::RESP_OKAY : lane_cfg_pkg::RESP_SLVERR;
            end
            if (bvalid_q && bready_i)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // read channel, data registered one cycle after the address
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h0000_0000;
            rd_idx_q  <= 6'h00;
        end
        else
        begin
            if (arvalid_i && arready_q)
            begin
                arready_q <= 1'b0;
                rd_idx_q  <= araddr_i[7:2];
            end
            if (rd_fire)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= acc.rd_ok ? acc.rd_data : 32'h0000_0000;
                rresp_q  <= acc.rd_ok ? lane_cfg_pkg::RESP_OKAY : lane_cfg_pkg::RESP_SLVERR;
            end
            if (rvalid_q && rready_i)
            begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // outputs and register file strobes
    assign awready_o   = awready_q;
    assign wready_o    = wready_q;
    assign bvalid_o    = bvalid_q;
    assign bresp_o     = bresp_q;
    assign arready_o   = arready_q;
    assign rvalid_o    = rvalid_q;
    assign rresp_o     = rresp_q;
    assign rdata_o     = rdata_q;
    assign acc.wr_en   = wr_fire;
    assign acc.wr_idx  = wr_idx_q;
    assign acc.wr_data = wr_data_q;
    assign acc.wr_strb = wr_strb_q;
    assign acc.rd_idx  = rd_idx_q;

    // ----------------------------------------------------------------
    // bus checks
    // ----------------------------------------------------------------
    property p_bvalid_hold;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        bvalid_q && !bready_i |=> bvalid_q && $stable(bresp_q);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped before bready");

    property p_read_latency;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        arvalid_i && arready_q && !rvalid_q |=> !arready_q ##1 rvalid_q;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data not one cycle after address");

    c_write_done: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) bvalid_q && bready_i);
    c_read_done: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) rvalid_q && rready_i);
    c_slverr: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        bvalid_q && bresp_q == lane_cfg_pkg::RESP_SLVERR);

endmodule : axil_reg_port

// ===== rtl/lane_8b10b_config_regs.sv
// Summary of operation
// R1: the octet swap flavour bit selects the ieee 1000base-x/t swap when clear and fibre channel when set.
// R2: software keeps the gear width consistent with the tx fifo read and rx fifo write clock sources.
// R3: software loads the fabric path select with four to route the lane through the 8b10b overlay.
// R4: a four-bit serializer lane mode field selects which lane mode feeds the serializer.
// R5: software should set both fabric clock sources to one unless the rx fifo synchronous enable is used.
// R6: software sets the coder rx clock source to three whenever 8b10b is used.
// R7: software picks the rx fifo write clock source to agree with the gear width.
// R8: the rx fifo clock side bit is cleared for 8b10b operation.
// R9: software sets the coder rx clock enable for 8b10b operation.
// R10: separate enables drive the coder tx clock, the rx fifo write clock and the tx fifo read clock.
// R11: software sets the deserializer width to seven, the forty-bit mode.
// R12: a three-bit serializer width field selects the serializer parallel width.
// R13: software clears the slip source select so the fabric controls alignment.
// R14: software sets the slip enable; clearing it stops alignment.
// R15: software programs all fields before the lane pcs and pma resets are released.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lane_cfg.svh"

module lane_8b10b_config_regs (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // pcs lane fields
    output logic             octet_swap_flavour_o,
    output logic [1:0]       fifo_gear_width_o,
    output logic [3:0]       fabric_path_select_o,
    output logic [3:0]       serializer_lane_mode_o,
    // clock module fields
    output logic [1:0]       fabric_rx_clock_source_o,
    output logic [1:0]       fabric_tx_clock_source_o,
    output logic [1:0]       coder_rx_clock_source_o,
    output logic [1:0]       coder_tx_clock_source_o,
    output logic [1:0]       rx_fifo_write_clock_source_o,
    output logic [1:0]       tx_fifo_read_clock_source_o,
    output logic             rx_fifo_clock_side_o,
    output logic             coder_rx_clock_enable_o,
    output logic             rx_fifo_write_clock_enable_o,
    output logic             coder_tx_clock_enable_o,
    output logic             tx_fifo_read_clock_enable_o,
    // pma lane fields
    output logic [2:0]       deser_width_o,
    output logic [2:0]       ser_width_o,
    output logic             slip_source_select_o,
    output logic             slip_enable_o,
    // configuration check
    output logic             config_8b10b_ok_o
);

    // ----------------------------------------------------------------
    // bus port
    // ----------------------------------------------------------------
    reg_access_if acc ();

    axil_reg_port u_port (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .awaddr_i   (s_axi_awaddr_i),
        .awvalid_i  (s_axi_awvalid_i),
        .awready_o  (s_axi_awready_o),
        .wdata_i    (s_axi_wdata_i),
        .wstrb_i    (s_axi_wstrb_i),
        .wvalid_i   (s_axi_wvalid_i),
        .wready_o   (s_axi_wready_o),
        .bresp_o    (s_axi_bresp_o),
        .bvalid_o   (s_axi_bvalid_o),
        .bready_i   (s_axi_bready_i),
        .araddr_i   (s_axi_araddr_i),
        .arvalid_i  (s_axi_arvalid_i),
        .arready_o  (s_axi_arready_o),
        .rdata_o    (s_axi_rdata_o),
        .rresp_o    (s_axi_rresp_o),
        .rvalid_o   (s_axi_rvalid_o),
        .rready_i   (s_axi_rready_i),
        .acc        (acc.port)
    );

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [31:0] options_q;
    logic [31:0] overlay_q;
    logic [31:0] clk_sel_q;
    logic [31:0] clk_ena_q;
    logic [31:0] deser_q;
    logic [31:0] ser_q;
    logic [31:0] cdr_q;
    logic [8:0]  status_q;
    logic [8:0]  status_d;
    logic [31:0] wr_cur;
    logic [31:0] wr_merged;

    // word view of a register slot, shared by read and write merge
    function automatic logic [31:0] reg_word(input logic [5:0] idx);
        case (idx)
            `LCR_IDX_OPTIONS: reg_word = options_q;
            `LCR_IDX_OVERLAY: reg_word = overlay_q;
            `LCR_IDX_CLK_SEL: reg_word = clk_sel_q;
            `LCR_IDX_CLK_ENA: reg_word = clk_ena_q;
            `LCR_IDX_DESER:   reg_word = deser_q;
            `LCR_IDX_SER:     reg_word = ser_q;
            `LCR_IDX_CDR:     reg_word = cdr_q;
            `LCR_IDX_STATUS:  reg_word = {23'h000000, status_q};
            default:          reg_word = 32'h0000_0000;
        endcase
    endfunction : reg_word

    // status is read only, so writes to it are refused like holes
    assign acc.wr_ok   = (acc.wr_idx < `LCR_IDX_STATUS);
    assign acc.rd_ok   = (acc.rd_idx <= `LCR_IDX_STATUS);

    // a process so the read word follows register updates while the index stands still
    always_comb
    begin
        acc.rd_data = reg_word(acc.rd_idx);
        wr_cur      = reg_word(acc.wr_idx);
    end

    // byte strobes keep unselected lanes at their old value
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_lane
            assign wr_merged[gb*8 +: 8] = acc.wr_strb[gb] ? acc.wr_data[gb*8 +: 8] : wr_cur[gb*8 +: 8];
        end
    endgenerate

    // writes, masked so that unused bits always read zero
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            options_q <= `LCR_RST_WORD;
            overlay_q <= `LCR_RST_WORD;
            clk_sel_q <= `LCR_RST_WORD;
            clk_ena_q <= `LCR_RST_WORD;
            deser_q   <= `LCR_RST_WORD;
            ser_q     <= `LCR_RST_WORD;
            cdr_q     <= `LCR_RST_WORD;
        end
        else if (acc.wr_en)
        begin
            case (acc.wr_idx)
                `LCR_IDX_OPTIONS: options_q <= wr_merged & `LCR_MASK_OPTIONS; // R1
                `LCR_IDX_OVERLAY: overlay_q <= wr_merged & `LCR_MASK_OVERLAY; // R4
                `LCR_IDX_CLK_SEL: clk_sel_q <= wr_merged & `LCR_MASK_CLK_SEL;
                `LCR_IDX_CLK_ENA: clk_ena_q <= wr_merged & `LCR_MASK_CLK_ENA; // R10
                `LCR_IDX_DESER:   deser_q   <= wr_merged & `LCR_MASK_WIDTH;
                `LCR_IDX_SER:     ser_q     <= wr_merged & `LCR_MASK_WIDTH;   // R12
                `LCR_IDX_CDR:     cdr_q     <= wr_merged & `LCR_MASK_CDR;
                default:          ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // 8b10b configuration check
    // ----------------------------------------------------------------
    // gear and fifo clock agreement is not checked: the pairing is not fixed here
    always_comb
    begin
        status_d    = 9'h000;
        status_d[0] = overlay_q[`LCR_FABPATH_RNG] == `LCR_REQ_FABPATH;                 // R3
        status_d[1] = clk_sel_q[`LCR_CODRX_RNG] == `LCR_REQ_CODRX;                     // R6
        status_d[2] = clk_sel_q[`LCR_RXSIDE_BIT] == `LCR_REQ_RXSIDE;                   // R8
        status_d[3] = clk_ena_q[`LCR_CODRX_EN_BIT] == `LCR_REQ_ENA;                    // R9
        status_d[4] = deser_q[`LCR_WIDTH_RNG] == `LCR_REQ_DESER;                       // R11
        status_d[5] = cdr_q[`LCR_SLIPSRC_BIT] == `LCR_REQ_SLIPSRC;                     // R13
        status_d[6] = cdr_q[`LCR_SLIPEN_BIT] == `LCR_REQ_SLIPEN;                       // R14
        status_d[7] = (clk_sel_q[`LCR_FABRX_RNG] == `LCR_REQ_FABCLK)
                   && (clk_sel_q[`LCR_FABTX_RNG] == `LCR_REQ_FABCLK);                  // R5
        status_d[8] = &status_d[6:0];                                                  // R15
    end

    // registered so the flag output comes from a flop
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            status_q <= 9'h000;
        else
            status_q <= status_d;
    end

    // ----------------------------------------------------------------
    // field outputs
    // ----------------------------------------------------------------
    assign octet_swap_flavour_o         = options_q[`LCR_SWAP_BIT];    // R1
    assign fifo_gear_width_o            = options_q[`LCR_GEAR_RNG];
    assign fabric_path_select_o         = overlay_q[`LCR_FABPATH_RNG];
    assign serializer_lane_mode_o       = overlay_q[`LCR_LANEMODE_RNG]; // R4
    assign fabric_rx_clock_source_o     = clk_sel_q[`LCR_FABRX_RNG];
    assign fabric_tx_clock_source_o     = clk_sel_q[`LCR_FABTX_RNG];
    assign coder_rx_clock_source_o      = clk_sel_q[`LCR_CODRX_RNG];
    assign coder_tx_clock_source_o      = clk_sel_q[`LCR_CODTX_RNG];
    assign rx_fifo_write_clock_source_o = clk_sel_q[`LCR_RXWCLK_RNG];
    assign tx_fifo_read_clock_source_o  = clk_sel_q[`LCR_TXRCLK_RNG];
    assign rx_fifo_clock_side_o         = clk_sel_q[`LCR_RXSIDE_BIT];
    assign coder_rx_clock_enable_o      = clk_ena_q[`LCR_CODRX_EN_BIT];
    assign rx_fifo_write_clock_enable_o = clk_ena_q[`LCR_RXWCLK_EN_BIT]; // R10
    assign coder_tx_clock_enable_o      = clk_ena_q[`LCR_CODTX_EN_BIT];  // R10
    assign tx_fifo_read_clock_enable_o  = clk_ena_q[`LCR_TXRCLK_EN_BIT]; // R10
    assign deser_width_o                = deser_q[`LCR_WIDTH_RNG];
    assign ser_width_o                  = ser_q[`LCR_WIDTH_RNG];        // R12
    assign slip_source_select_o         = cdr_q[`LCR_SLIPSRC_BIT];
    assign slip_enable_o                = cdr_q[`LCR_SLIPEN_BIT];
    assign config_8b10b_ok_o            = status_q[8];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_swap_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        acc.wr_en && acc.wr_idx == `LCR_IDX_OPTIONS && acc.wr_strb[0]
        |=> octet_swap_flavour_o == $past(acc.wr_data[0]);
    endproperty
    a_swap_write: assert property (p_swap_write) else $error("swap flavour not taken from write"); // R1

    property p_lane_mode_src;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $changed(serializer_lane_mode_o) |-> $past(acc.wr_en && acc.wr_idx == `LCR_IDX_OVERLAY);
    endproperty
    a_lane_mode_src: assert property (p_lane_mode_src) else $error("lane mode changed without write"); // R4

    property p_enable_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        acc.wr_en && acc.wr_idx == `LCR_IDX_CLK_ENA && acc.wr_strb[0]
        |=> {tx_fifo_read_clock_enable_o, coder_tx_clock_enable_o, rx_fifo_write_clock_enable_o}
            == $past(acc.wr_data[3:1]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("clock enables not taken from write"); // R10

    property p_ser_hold;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !(acc.wr_en && acc.wr_idx == `LCR_IDX_SER) |=> $stable(ser_width_o);
    endproperty
    a_ser_hold: assert property (p_ser_hold) else $error("serializer width changed without write"); // R12

    c_fc_swap: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) $rose(octet_swap_flavour_o));
    c_cfg_ok: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) $rose(config_8b10b_ok_o));

endmodule : lane_8b10b_config_regs

// ===== rtl/lane_cfg.svh
`ifndef LANE_8B10B_CFG_SVH
`define LANE_8B10B_CFG_SVH

// ----------------------------------------------------------------
// register word indices
// ----------------------------------------------------------------
`define LCR_IDX_W          6
`define LCR_IDX_OPTIONS    6'h00
`define LCR_IDX_OVERLAY    6'h01
`define LCR_IDX_CLK_SEL    6'h02
`define LCR_IDX_CLK_ENA    6'h03
`define LCR_IDX_DESER      6'h04
`define LCR_IDX_SER        6'h05
`define LCR_IDX_CDR        6'h06
`define LCR_IDX_STATUS     6'h07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LCR_SWAP_BIT       0
`define LCR_GEAR_RNG       2:1
`define LCR_FABPATH_RNG    3:0
`define LCR_LANEMODE_RNG   7:4
`define LCR_FABRX_RNG      1:0
`define LCR_FABTX_RNG      3:2
`define LCR_CODRX_RNG      5:4
`define LCR_CODTX_RNG      7:6
`define LCR_RXWCLK_RNG     9:8
`define LCR_TXRCLK_RNG     11:10
`define LCR_RXSIDE_BIT     12
`define LCR_ENA_RNG        3:0
`define LCR_CODRX_EN_BIT   0
`define LCR_RXWCLK_EN_BIT  1
`define LCR_CODTX_EN_BIT   2
`define LCR_TXRCLK_EN_BIT  3
`define LCR_WIDTH_RNG      2:0
`define LCR_SLIPSRC_BIT    0
`define LCR_SLIPEN_BIT     1

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define LCR_MASK_OPTIONS   32'h0000_0007
`define LCR_MASK_OVERLAY   32'h0000_00FF
`define LCR_MASK_CLK_SEL   32'h0000_1FFF
`define LCR_MASK_CLK_ENA   32'h0000_000F
`define LCR_MASK_WIDTH     32'h0000_0007
`define LCR_MASK_CDR       32'h0000_0003
`define LCR_RST_WORD       32'h0000_0000

// ----------------------------------------------------------------
// values expected for 8b10b operation
// ----------------------------------------------------------------
`define LCR_REQ_FABPATH    4'h4
`define LCR_REQ_FABCLK     2'h1
`define LCR_REQ_CODRX      2'h3
`define LCR_REQ_RXSIDE     1'h0
`define LCR_REQ_ENA        1'h1
`define LCR_REQ_DESER      3'h7
`define LCR_REQ_SLIPSRC    1'h0
`define LCR_REQ_SLIPEN     1'h1

`endif

// ===== rtl/lane_cfg_pkg.sv
package lane_cfg_pkg;

    // octet swap flavour
    typedef enum logic {
        SWAP_IEEE = 1'h0,
        SWAP_FC   = 1'h1
    } swap_flavour_e;

    // axi response codes
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_e;

endpackage : lane_cfg_pkg

// ===== rtl/reg_access_if.sv
`timescale 1ns/1ps

// register access strobes between bus port and register file
interface reg_access_if;
    logic        wr_en;
    logic [5:0]  wr_idx;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic [5:0]  rd_idx;
    logic [31:0] rd_data;
    logic        rd_ok;

    modport port (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output wr_ok, rd_data, rd_ok);
endinterface : reg_access_if
